// *** tcss_clock_select.v ***
`timescale 1ns/10ps
`include "tcss_consts.vh"
module tcss_clock_select (
   input  wire       clk_i,
   input  wire       rstn_i,
   input  wire       sfr_wr_i,
   input  wire       sfr_rd_i,
   input  wire [7:0] sfr_addr_i,
   input  wire [7:0] sfr_wdata_i,
   output reg  [7:0] sfr_rdata_o,
   input  wire       ext_clk_i,
   input  wire       t0_pin_i,
   input  wire       t1_pin_i,
   input  wire       timer0_event_count_mode_i,
   input  wire       timer1_event_count_mode_i,
   input  wire       timer2_alt_clock_sel_i,
   input  wire       timer3_alt_clock_sel_i,
   output reg        timer0_tick_o,
   output reg        timer1_tick_o,
   output reg        timer2_lower_tick_o,
   output reg        timer2_upper_tick_o,
   output reg        timer3_lower_tick_o,
   output reg        timer3_upper_tick_o
);
   reg  [7:0] timer_clock_control_reg;
   reg  [2:0] ext_sync_reg;
   reg  [2:0] t0_sync_reg;
   reg  [2:0] t1_sync_reg;
   reg  [2:0] ext_cnt_reg;
   reg        ext_tick_reg;
   wire       div4_tick;
   wire       div12_tick;
   wire       div48_tick;
   wire       ext_rise;
   wire       t0_fall;
   wire       t1_fall;
   reg        prescale_tick;
   wire       alt2_tick;
   wire       alt3_tick;
   reg        timer0_tick_next;
   reg        timer1_tick_next;
   reg        timer2_lower_tick_next;
   reg        timer2_upper_tick_next;
   reg        timer3_lower_tick_next;
   reg        timer3_upper_tick_next;

   wire [1:0] prescale_select        =
              timer_clock_control_reg[`TCSS_PRESCALE_HI:`TCSS_PRESCALE_LO];
   wire       timer0_sysclk_sel      = timer_clock_control_reg[`TCSS_T0_SYSCLK_BIT];
   wire       timer1_sysclk_sel      = timer_clock_control_reg[`TCSS_T1_SYSCLK_BIT];
   wire       timer2_lower_clock_sel = timer_clock_control_reg[`TCSS_T2_LOWER_BIT];
   wire       timer2_upper_clock_sel = timer_clock_control_reg[`TCSS_T2_UPPER_BIT];
   wire       timer3_lower_clock_sel = timer_clock_control_reg[`TCSS_T3_LOWER_BIT];
   wire       timer3_upper_clock_sel = timer_clock_control_reg[`TCSS_T3_UPPER_BIT];

   // Pick between system clock (always enabled) and an alternate tick
   function pick;
      input sys_sel;
      input alt_tick;
      begin
         pick = sys_sel ? 1'b1 : alt_tick;
      end
   endfunction

   // Both strobes decode the same single address
   function reg_hit;
      input [7:0] addr;
      begin
         reg_hit = (addr == `TCSS_CLK_CTRL_ADDR);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register access; write and read on one edge returns the old value
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_clock_control_reg <= `TCSS_CLK_CTRL_RESET;
      end else if (sfr_wr_i && reg_hit(sfr_addr_i)) begin
         timer_clock_control_reg <= sfr_wdata_i;
      end
   end

   // Read data is zero off-address so several sources can be ORed
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i && reg_hit(sfr_addr_i)) begin
         sfr_rdata_o <= timer_clock_control_reg;
      end else begin
         sfr_rdata_o <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronizers; first stage feeds only the second
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ext_sync_reg <= 3'h0;
         t0_sync_reg  <= 3'h7;
         t1_sync_reg  <= 3'h7;
      end else begin
         ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_i};
         t0_sync_reg  <= {t0_sync_reg[1:0], t0_pin_i};
         t1_sync_reg  <= {t1_sync_reg[1:0], t1_pin_i};
      end
   end

   assign ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
   assign t0_fall  = ~t0_sync_reg[1] & t0_sync_reg[2];
   assign t1_fall  = ~t1_sync_reg[1] & t1_sync_reg[2];

   ////////////////////////////////////////////////////////////////////////////
   // External clock divide by eight, counted in system-clock domain
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ext_cnt_reg  <= 3'h0;
         ext_tick_reg <= 1'b0;
      end else begin
         ext_tick_reg <= 1'b0;
         if (ext_rise) begin
            ext_cnt_reg <= ext_cnt_reg + 3'h1;
            if (ext_cnt_reg == `TCSS_EXT_DIV) begin
               ext_tick_reg <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System clock dividers; all free-running so switching is glitch free
   tcss_divider u_div4 (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .step_i  (1'b1),
      .ratio_i (`TCSS_DIV4),
      .tick_o  (div4_tick)
   );

   tcss_divider u_div12 (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .step_i  (1'b1),
      .ratio_i (`TCSS_DIV12),
      .tick_o  (div12_tick)
   );

   tcss_divider u_div48 (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .step_i  (1'b1),
      .ratio_i (`TCSS_DIV48),
      .tick_o  (div48_tick)
   );

   // Shared Timer 0/1 tick; all sources keep running while unselected
   always @* begin
      case (prescale_select)
         `TCSS_PS_DIV12: prescale_tick = div12_tick;
         `TCSS_PS_DIV4:  prescale_tick = div4_tick;
         `TCSS_PS_DIV48: prescale_tick = div48_tick;
         `TCSS_PS_EXT8:  prescale_tick = ext_tick_reg;
         default:        prescale_tick = div12_tick;
      endcase
   end

   // Alternate clock for Timers 2 and 3
   assign alt2_tick = timer2_alt_clock_sel_i ? ext_tick_reg : div12_tick;
   assign alt3_tick = timer3_alt_clock_sel_i ? ext_tick_reg : div12_tick;

   ////////////////////////////////////////////////////////////////////////////
   // Next enable values; counter mode overrides the clock select bits
   always @* begin
      timer0_tick_next       = pick(timer0_sysclk_sel, prescale_tick);
      if (timer0_event_count_mode_i) begin
         timer0_tick_next    = t0_fall;
      end
      timer1_tick_next       = pick(timer1_sysclk_sel, prescale_tick);
      if (timer1_event_count_mode_i) begin
         timer1_tick_next    = t1_fall;
      end
      // Upper-byte enables run always; unsplit timers simply ignore them
      timer2_lower_tick_next = pick(timer2_lower_clock_sel, alt2_tick);
      timer2_upper_tick_next = pick(timer2_upper_clock_sel, alt2_tick);
      timer3_lower_tick_next = pick(timer3_lower_clock_sel, alt3_tick);
      timer3_upper_tick_next = pick(timer3_upper_clock_sel, alt3_tick);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered enable outputs, one cycle behind the source tick
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer0_tick_o       <= 1'b0;
         timer1_tick_o       <= 1'b0;
         timer2_lower_tick_o <= 1'b0;
         timer2_upper_tick_o <= 1'b0;
         timer3_lower_tick_o <= 1'b0;
         timer3_upper_tick_o <= 1'b0;
      end else begin
         timer0_tick_o       <= timer0_tick_next;
         timer1_tick_o       <= timer1_tick_next;
         timer2_lower_tick_o <= timer2_lower_tick_next;
         timer2_upper_tick_o <= timer2_upper_tick_next;
         timer3_lower_tick_o <= timer3_lower_tick_next;
         timer3_upper_tick_o <= timer3_upper_tick_next;
      end
   end
endmodule

// *** tcss_consts.vh ***
`ifndef TCSS_CONSTS_VH
`define TCSS_CONSTS_VH
// Register address and reset value
`define TCSS_CLK_CTRL_ADDR   8'h8E
`define TCSS_CLK_CTRL_RESET  8'h00
// Field positions
`define TCSS_T3_UPPER_BIT    7
`define TCSS_T3_LOWER_BIT    6
`define TCSS_T2_UPPER_BIT    5
`define TCSS_T2_LOWER_BIT    4
`define TCSS_T1_SYSCLK_BIT   3
`define TCSS_T0_SYSCLK_BIT   2
`define TCSS_PRESCALE_HI     1
`define TCSS_PRESCALE_LO     0
// Prescale codes
`define TCSS_PS_DIV12        2'h0
`define TCSS_PS_DIV4         2'h1
`define TCSS_PS_DIV48        2'h2
`define TCSS_PS_EXT8         2'h3
// Division ratios
`define TCSS_DIV4            6'h04
`define TCSS_DIV12           6'h0C
`define TCSS_DIV48           6'h30
`define TCSS_EXT_DIV         3'h7
`endif

// *** tcss_divider.v ***
`timescale 1ns/10ps
// Free-running divider: one-cycle pulse every ratio_i enabled cycles
module tcss_divider (
   input  wire       clk_i,
   input  wire       rstn_i,
   input  wire       step_i,
   input  wire [5:0] ratio_i,
   output reg        tick_o
);
   reg [5:0] cnt_reg;

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_reg <= 6'h00;
         tick_o  <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (step_i) begin
            if (cnt_reg >= ratio_i - 6'h01) begin
               cnt_reg <= 6'h00;
               tick_o  <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 6'h01;
            end
         end
      end
   end
endmodule

// *** tcss_monitor.sv ***
`timescale 1ns/10ps
module tcss_monitor (
   input wire       clk_i,
   input wire       rstn_i,
   input wire       sfr_wr_i,
   input wire       sfr_rd_i,
   input wire [7:0] sfr_addr_i,
   input wire [7:0] sfr_wdata_i,
   input wire [7:0] sfr_rdata_o,
   input wire       timer0_event_count_mode_i,
   input wire       timer1_event_count_mode_i,
   input wire       timer0_tick_o,
   input wire       timer1_tick_o,
   input wire       timer2_lower_tick_o,
   input wire       timer2_upper_tick_o,
   input wire       timer3_lower_tick_o,
   input wire       timer3_upper_tick_o
);
   reg  [7:0] sel_reg;
   wire       rd_hit = sfr_rd_i && sfr_addr_i == 8'h8E;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Shadow copy so tick checks follow software writes
   always @(posedge clk_i or negedge rstn_i)
      if (!rstn_i) sel_reg <= 8'h00;
      else if (sfr_wr_i && sfr_addr_i == 8'h8E) sel_reg <= sfr_wdata_i;
   ////////////////////////////////////////////////////////////////
   sequence s_rd; rd_hit; endsequence
   property p_rd_val; s_rd |=> sfr_rdata_o == $past(sel_reg); endproperty
   a_rd_val: assert property (p_rd_val) else $error("read data");
   property p_rd_idle; !rd_hit |=> sfr_rdata_o == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("idle read data");
   property p_t0; sel_reg[2] && !timer0_event_count_mode_i |=> timer0_tick_o; endproperty
   a_t0: assert property (p_t0) else $error("timer0 tick");
   property p_t1; sel_reg[3] && !timer1_event_count_mode_i |=> timer1_tick_o; endproperty
   a_t1: assert property (p_t1) else $error("timer1 tick");
   property p_t2l; sel_reg[4] |=> timer2_lower_tick_o; endproperty
   a_t2l: assert property (p_t2l) else $error("timer2 lower tick");
   property p_t2u; sel_reg[5] |=> timer2_upper_tick_o; endproperty
   a_t2u: assert property (p_t2u) else $error("timer2 upper tick");
   property p_t3l; sel_reg[6] |=> timer3_lower_tick_o; endproperty
   a_t3l: assert property (p_t3l) else $error("timer3 lower tick");
   property p_t3u; sel_reg[7] |=> timer3_upper_tick_o; endproperty
   a_t3u: assert property (p_t3u) else $error("timer3 upper tick");
endmodule
bind tcss_clock_select tcss_monitor i_tcss_monitor (.*);

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
   reg        clk_i = 1'b0;
   reg        rstn_i = 1'b0;
   reg        wr = 1'b0;
   reg        rd = 1'b0;
   reg  [7:0] addr = 8'h00;
   reg  [7:0] wdata = 8'h00;
   reg        ext_run = 1'b0;
   reg        pin_run = 1'b0;
   reg        ext_clk = 1'b0;
   reg        mode = 1'b0;
   reg        alt = 1'b0;
   reg  [2:0] ph = 3'h0;
   wire [7:0] rdata;
   wire [5:0] tk;
   integer    miscompares = 0;
   integer    n_tests = 0;
   integer    cyc = 0;
   integer    i;
   // Pin idles high, falls once every 8 cycles while running
   wire       pin = ~pin_run | ph[2];
   tcss_clock_select i_tcss_clock_select (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_wr_i(wr),
      .sfr_rd_i(rd), .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
      .ext_clk_i(ext_clk), .t0_pin_i(pin), .t1_pin_i(pin), .timer0_event_count_mode_i(mode),
      .timer1_event_count_mode_i(mode), .timer2_alt_clock_sel_i(alt),
      .timer3_alt_clock_sel_i(alt), .timer0_tick_o(tk[0]), .timer1_tick_o(tk[1]),
      .timer2_lower_tick_o(tk[2]), .timer2_upper_tick_o(tk[3]),
      .timer3_lower_tick_o(tk[4]), .timer3_upper_tick_o(tk[5]));
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      ph <= ph + 3'h1;
      if (ext_run) ext_clk <= ph[2];
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares = miscompares + 1;
         give_verdict;
      end
   end
   ////////////////////////////////////////////////////////////////
   task check(input [7:0] seen, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wreg(input [7:0] a, input [7:0] d);
      begin
         wr <= 1'b1;
         addr <= a;
         wdata <= d;
         @(posedge clk_i);
         wr <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
   endtask
   task rreg(input [7:0] a, input [7:0] exp);
      begin
         rd <= 1'b1;
         addr <= a;
         @(posedge clk_i);
         rd <= 1'b0;
         #1 check(rdata, exp);
         @(posedge clk_i);
      end
   endtask
   // Exact pulse count over n whole cycles, so stuck-high also fails
   task count(input integer k, input integer n, input [7:0] exp);
      integer c;
      begin
         c = 0;
         repeat (n) begin
            @(posedge clk_i);
            #1 c = c + tk[k];
         end
         @(posedge clk_i);
         check(c[7:0], exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task t_reg;
      begin
         rreg(8'h8E, 8'h00);
         wreg(8'h8E, 8'hA5);
         wreg(8'h8F, 8'h5A);
         rreg(8'h8F, 8'h00);
         rreg(8'h8E, 8'hA5);
      end
   endtask
   task t_sys;
      begin
         wreg(8'h8E, 8'hFC);
         for (i = 0; i < 6; i = i + 1) count(i, 8, 8'h08);
      end
   endtask
   task t_pre;
      begin
         wreg(8'h8E, 8'h00);
         count(0, 96, 8'h08);
         count(2, 96, 8'h08);
         count(3, 96, 8'h08);
         count(5, 96, 8'h08);
         wreg(8'h8E, 8'h01);
         count(1, 96, 8'h18);
         wreg(8'h8E, 8'h02);
         count(0, 96, 8'h02);
      end
   endtask
   task t_ext;
      begin
         wreg(8'h8E, 8'h03);
         alt <= 1'b1;
         ext_run <= 1'b1;
         repeat (80) @(posedge clk_i);
         count(0, 128, 8'h02);
         count(2, 128, 8'h02);
         count(4, 128, 8'h02);
         ext_run <= 1'b0;
      end
   endtask
   task t_cnt;
      begin
         mode <= 1'b1;
         pin_run <= 1'b1;
         wreg(8'h8E, 8'h0C);
         repeat (16) @(posedge clk_i);
         count(0, 64, 8'h08);
         count(1, 64, 8'h08);
      end
   endtask
   task give_verdict;
      begin
         $display("compares %0d mismatches %0d", n_tests, miscompares);
         if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      t_reg;
      t_sys;
      t_pre;
      t_ext;
      t_cnt;
      give_verdict;
   end
endmodule
